/* hw/fault_status_regs.svh */
// Register map, field positions and reset values of the fault status block.
`ifndef FAULT_STATUS_REGS_SVH
`define FAULT_STATUS_REGS_SVH

// ************************************************************
// Addresses
// ************************************************************
`define COMB_FAULT_ADDR     32'he000ed28
`define MEM_FAULT_STAT_ADDR 32'he000ed28
`define BUS_FAULT_STAT_ADDR 32'he000ed29
`define USG_FAULT_STAT_ADDR 32'he000ed2a
`define HANDLER_CTRL_ADDR   32'he000ed24

// ************************************************************
// Combined fault status fields
// ************************************************************
`define MF_INSTR      0
`define MF_DATA       1
`define MF_UNSTACK    3
`define MF_STACK      4
`define MF_ADDR_VALID 7
`define BF_IBUS       8
`define BF_PRECISE    9
`define BF_IMPRECISE  10
`define BF_UNSTACK    11
`define BF_STACK      12
`define BF_ADDR_VALID 15
`define UF_LSB        16
`define FAULT_IMPL_MASK 32'hffff9f9b
`define FAULT_RESET     32'h00000000

// ************************************************************
// Handler control and state fields
// ************************************************************
`define HC_MEM_ACT   0
`define HC_BUS_ACT   1
`define HC_USG_ACT   3
`define HC_SVC_ACT   7
`define HC_MON_ACT   8
`define HC_PSV_ACT   10
`define HC_TICK_ACT  11
`define HC_USG_PEND  12
`define HC_MEM_PEND  13
`define HC_BUS_PEND  14
`define HC_SVC_PEND  15
`define HC_MEM_ENA   16
`define HC_BUS_ENA   17
`define HC_USG_ENA   18
`define HC_IMPL_MASK 32'h0007fd8b
`define HC_RESET     32'h00000000

// ************************************************************
// Exception numbers
// ************************************************************
`define EXC_MEM  4'h4
`define EXC_BUS  4'h5
`define EXC_USG  4'h6
`define EXC_SVC  4'hb
`define EXC_MON  4'hc
`define EXC_PSV  4'he
`define EXC_TICK 4'hf

`endif

/* hw/fault_status_pkg.sv */
// Types shared by the fault status block.
package fault_status_pkg;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } acc_size_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        acc_size_t   size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        mem_stack;
        logic        mem_unstack;
        logic        data_viol;
        logic        instr_viol;
        logic        bus_stack;
        logic        bus_unstack;
        logic        imprecise;
        logic        precise;
        logic        ibus_prefetch;
        logic        ibus_issue;
        logic        ibus_flush;
        logic [15:0] usage;
        logic [31:0] addr;
    } fault_evt_t;

    typedef struct packed {
        logic       enter;
        logic       ret;
        logic [3:0] num;
        logic       svc_req;
    } exc_evt_t;

endpackage

/* hw/fault_flag_bank.sv */
// Sticky write-one-to-clear flag bank.
`timescale 1ns/100ps
module fault_flag_bank (
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic [31:0] set_in,
    input  wire logic [31:0] sw_clr_in,
    input  wire logic [31:0] hw_clr_in,
    output logic      [31:0] flags_out
);
`include "fault_status_regs.svh"

    logic [31:0] flags_q;
    logic [31:0] flags_d;

    // A flag set in the same cycle as its clear stays set, so no fault is lost.
    assign flags_d = ((flags_q & ~(sw_clr_in | hw_clr_in)) | set_in) & `FAULT_IMPL_MASK;
    assign flags_out = flags_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_q <= `FAULT_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

/* hw/fault_status_capture.sv */
// Fault status capture and system handler state for the processor.
//
// Summary of operation
// - Active bits read 1 while debug monitor, svc, usage, bus, mem fault active.
// - A fault whose handler is disabled escalates to a hard fault.
// - Writes to handler control state change pending and active status.
// - Combined word: usage in 31:16, bus in 15:8, mem protect in 7:0.
// - Base: word gives all, byte gives mem byte, halfword gives mem and bus.
// - Bus byte alone at base plus one; usage halfword at base plus two.
// - Mem byte: valid 7, stacking 4, unstacking 3, data 1, instruction 0.
// - Mem address valid set by data violation; a later precise bus error overwrites the address but leaves it set.
// - Mem stacking violation sets its flag and captures no address.
// - Mem unstacking violation sets flag, chains to handler, captures no address.
// - Data access violation sets flag and loads the attempted address.
// - Instruction access violation sets flag and writes no address.
// - Bus byte: valid 7, stacking 4, unstacking 3, imprecise 2, precise 1, ibus 0.
// - Bus address valid set after known-address bus fault; later data access violation clears.
// - Bus stacking error sets its flag and writes no address.
// - Bus unstacking error sets flag, chains to handler, writes no address.
// - Imprecise error sets flag, no address; stays pending while priority blocks it.
// - A precise fault before imprecise handler entry shows both flags set.
// - Precise bus error sets flag and writes faulting address.
// - Instruction bus error flag set only when faulting prefetch is issued.
// - Usage bits stay set until written with one or reset.
`timescale 1ns/100ps
module fault_status_capture
    import fault_status_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire reg_req_t    req_in,
    input  wire fault_evt_t  fault_in,
    input  wire exc_evt_t    exc_in,
    output logic             resp_valid_out,
    output logic             resp_err_out,
    output logic      [31:0] rdata_out,
    output logic             hard_fault_out,
    output logic             handler_chain_out,
    output logic             mem_addr_wr_out,
    output logic             bus_addr_wr_out,
    output logic      [31:0] fault_addr_out,
    output logic      [31:0] handler_state_out
);
`include "fault_status_regs.svh"

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [3:0] lanes_of(input logic [1:0] a, input acc_size_t s);
        logic [3:0] l;
        l = 4'h0;
        unique case (s)
            SZ_BYTE: l = 4'h1 << a;
            SZ_HALF: l = a[0] ? 4'h0 : (a[1] ? 4'hc : 4'h3);
            SZ_WORD: l = (a == 2'b00) ? 4'hf : 4'h0;
            default: l = 4'h0;
        endcase
        return l;
    endfunction

    function automatic logic [31:0] expand(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction

    function automatic logic [31:0] act_bit(input logic [3:0] n);
        logic [31:0] m;
        m = 32'h0;
        unique case (n)
            `EXC_MEM:  m[`HC_MEM_ACT] = 1'b1;
            `EXC_BUS:  m[`HC_BUS_ACT] = 1'b1;
            `EXC_USG:  m[`HC_USG_ACT] = 1'b1;
            `EXC_SVC:  m[`HC_SVC_ACT] = 1'b1;
            `EXC_MON:  m[`HC_MON_ACT] = 1'b1;
            `EXC_PSV:  m[`HC_PSV_ACT] = 1'b1;
            `EXC_TICK: m[`HC_TICK_ACT] = 1'b1;
            default:   m = 32'h0;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] pend_bit(input logic [3:0] n);
        logic [31:0] m;
        m = 32'h0;
        unique case (n)
            `EXC_MEM: m[`HC_MEM_PEND] = 1'b1;
            `EXC_BUS: m[`HC_BUS_PEND] = 1'b1;
            `EXC_USG: m[`HC_USG_PEND] = 1'b1;
            `EXC_SVC: m[`HC_SVC_PEND] = 1'b1;
            default:  m = 32'h0;
        endcase
        return m;
    endfunction

    // ************************************************************
    // Register access decode
    // ************************************************************
    logic [31:0] flags;
    logic [31:0] hc_q;
    logic [31:0] hc_d;
    logic [3:0]  lanes;
    logic [31:0] lane_mask;
    logic        hit_fault;
    logic        hit_hc;
    logic        hit_ok;
    logic [31:0] sel_word;
    logic [31:0] sw_clr;

    // Sub-register views at the base, base plus one and base plus two are lane slices.
    assign lanes     = lanes_of(req_in.addr[1:0], req_in.size);
    assign lane_mask = expand(lanes);
    assign hit_fault = req_in.addr[31:2] == 30'(`COMB_FAULT_ADDR >> 2);
    assign hit_hc    = req_in.addr[31:2] == 30'(`HANDLER_CTRL_ADDR >> 2);
    assign hit_ok    = req_in.valid && (hit_fault || hit_hc) && (lanes != 4'h0);
    assign sel_word  = hit_fault ? flags : hc_q;
    assign sw_clr    = (hit_ok && req_in.write && hit_fault) ? (req_in.wdata & lane_mask)
                                                             : 32'h0;

    // ************************************************************
    // Fault flag sources
    // ************************************************************
    logic        ibus_bad_q;
    logic        ibus_hit;
    logic [31:0] set_v;
    logic [31:0] hw_clr;
    logic        mem_any;
    logic        bus_any;
    logic        usg_any;

    // A prefetch error is held until the instruction is issued or flushed.
    assign ibus_hit = fault_in.ibus_issue && (ibus_bad_q || fault_in.ibus_prefetch);

    always_comb begin
        set_v = 32'h0;
        set_v[`MF_STACK]      = fault_in.mem_stack;
        set_v[`MF_UNSTACK]    = fault_in.mem_unstack;
        set_v[`MF_DATA]       = fault_in.data_viol;
        set_v[`MF_INSTR]      = fault_in.instr_viol;
        set_v[`MF_ADDR_VALID] = fault_in.data_viol;
        set_v[`BF_STACK]      = fault_in.bus_stack;
        set_v[`BF_UNSTACK]    = fault_in.bus_unstack;
        set_v[`BF_IMPRECISE]  = fault_in.imprecise;
        set_v[`BF_PRECISE]    = fault_in.precise;
        set_v[`BF_IBUS]       = ibus_hit;
        set_v[`BF_ADDR_VALID] = fault_in.precise;
        set_v[31:16]          = fault_in.usage;
    end

    // A later data access violation reuses the address store, so bus valid drops.
    always_comb begin
        hw_clr = 32'h0;
        hw_clr[`BF_ADDR_VALID] = fault_in.data_viol;
    end

    // Sticky flags, cleared by a one written to the bit or by reset; bus address valid is also cleared by a data violation.
    fault_flag_bank u_flags (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .set_in    (set_v),
        .sw_clr_in (sw_clr),
        .hw_clr_in (hw_clr),
        .flags_out (flags)
    );

    assign mem_any = fault_in.mem_stack || fault_in.mem_unstack
                  || fault_in.data_viol || fault_in.instr_viol;
    assign bus_any = fault_in.bus_stack || fault_in.bus_unstack
                  || fault_in.imprecise || fault_in.precise || ibus_hit;
    assign usg_any = fault_in.usage != 16'h0;

    // ************************************************************
    // Handler control and state
    // ************************************************************
    logic [31:0] hc_wr;
    logic [31:0] fault_pend;
    logic [31:0] enter_act;
    logic [31:0] enter_pend;
    logic [31:0] ret_act;
    logic        esc;

    // Software may rewrite pending and active state, e.g. for a kernel context switch.
    assign hc_wr = (hit_ok && req_in.write && hit_hc)
                 ? ((hc_q & ~lane_mask) | (req_in.wdata & lane_mask)) : hc_q;
    assign enter_act  = exc_in.enter ? act_bit(exc_in.num) : 32'h0;
    assign enter_pend = exc_in.enter ? pend_bit(exc_in.num) : 32'h0;
    assign ret_act    = exc_in.ret ? act_bit(exc_in.num) : 32'h0;

    // An enabled fault becomes pending; a blocked imprecise one simply stays pending
    // until the core takes it, since only entry or a handler control write clears the bit.
    always_comb begin
        fault_pend = 32'h0;
        fault_pend[`HC_MEM_PEND] = mem_any && hc_q[`HC_MEM_ENA];
        fault_pend[`HC_BUS_PEND] = bus_any && hc_q[`HC_BUS_ENA];
        fault_pend[`HC_USG_PEND] = usg_any && hc_q[`HC_USG_ENA];
        fault_pend[`HC_SVC_PEND] = exc_in.svc_req;
    end

    assign hc_d = (((hc_wr & ~(enter_pend | ret_act)) | enter_act | fault_pend))
                & `HC_IMPL_MASK;

    // A disabled handler hands its fault to the hard fault handler.
    assign esc = (mem_any && !hc_q[`HC_MEM_ENA]) || (bus_any && !hc_q[`HC_BUS_ENA])
              || (usg_any && !hc_q[`HC_USG_ENA]);

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hc_q       <= `HC_RESET;
            ibus_bad_q <= 1'b0;
        end else begin
            hc_q       <= hc_d;
            ibus_bad_q <= (ibus_bad_q || fault_in.ibus_prefetch)
                       && !fault_in.ibus_issue && !fault_in.ibus_flush;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            resp_valid_out <= 1'b0;
            resp_err_out   <= 1'b0;
            rdata_out      <= 32'h0;
        end else begin
            resp_valid_out <= req_in.valid;
            resp_err_out   <= req_in.valid && !hit_ok;
            rdata_out      <= (hit_ok && !req_in.write) ? (sel_word & lane_mask) : 32'h0;
        end
    end

    // Only data violations and precise errors capture an address.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hard_fault_out    <= 1'b0;
            handler_chain_out <= 1'b0;
            mem_addr_wr_out   <= 1'b0;
            bus_addr_wr_out   <= 1'b0;
            fault_addr_out    <= 32'h0;
            handler_state_out <= `HC_RESET;
        end else begin
            hard_fault_out    <= esc;
            handler_chain_out <= fault_in.mem_unstack || fault_in.bus_unstack;
            mem_addr_wr_out   <= fault_in.data_viol;
            bus_addr_wr_out   <= fault_in.precise;
            if (fault_in.data_viol || fault_in.precise) begin
                fault_addr_out <= fault_in.addr;
            end
            handler_state_out <= hc_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_MEM_ADDR_LOAD: assert property (
        fault_in.data_viol |=> mem_addr_wr_out && fault_addr_out == $past(fault_in.addr)
                               && flags[`MF_DATA] && flags[`MF_ADDR_VALID])
        else $error("data violation did not capture its address");

    AST_NO_ADDR_STACK: assert property (
        (fault_in.mem_stack || fault_in.mem_unstack || fault_in.instr_viol
         || fault_in.bus_stack || fault_in.bus_unstack || fault_in.imprecise)
        && !fault_in.data_viol && !fault_in.precise
        |=> !mem_addr_wr_out && !bus_addr_wr_out)
        else $error("address captured for a fault that has none");

    AST_PRECISE: assert property (
        fault_in.precise |=> flags[`BF_PRECISE] && flags[`BF_ADDR_VALID] && bus_addr_wr_out)
        else $error("precise bus error not recorded");

    AST_IBUS_ISSUE: assert property (
        $rose(flags[`BF_IBUS]) |-> $past(fault_in.ibus_issue))
        else $error("instruction bus error set without issue");

    AST_USAGE_STICKY: assert property (
        flags[`UF_LSB] && !sw_clr[`UF_LSB] |=> flags[`UF_LSB])
        else $error("usage flag dropped without a clear");

    AST_ESCALATE: assert property (
        usg_any && !hc_q[`HC_USG_ENA] |=> hard_fault_out)
        else $error("disabled usage fault not escalated");

    AST_ACTIVE: assert property (
        exc_in.enter && exc_in.num == `EXC_BUS ##1 !exc_in.ret [*2]
        |-> handler_state_out[`HC_BUS_ACT])
        else $error("bus fault active bit not shown");

    AST_MEM_VALID: assert property (
        $rose(flags[`MF_ADDR_VALID]) |-> $past(fault_in.data_viol))
        else $error("mem address valid set without capture");

    AST_BUS_VALID_CLR: assert property (
        fault_in.data_viol && !fault_in.precise |=> !flags[`BF_ADDR_VALID])
        else $error("bus address valid kept after mem fault");

    AST_WORD_READ: assert property (
        req_in.valid && !req_in.write && hit_fault && req_in.size == SZ_WORD
        && req_in.addr[1:0] == 2'b00 |=> rdata_out == $past(flags) && resp_valid_out)
        else $error("combined word read layout wrong");

    AST_MEM_STACK: assert property (
        fault_in.mem_stack && !fault_in.data_viol |=> flags[`MF_STACK] && !mem_addr_wr_out)
        else $error("mem stacking error not recorded");

    AST_MEM_UNSTACK: assert property (
        fault_in.mem_unstack |=> flags[`MF_UNSTACK] && handler_chain_out)
        else $error("mem unstacking error not chained");

    AST_INSTR_VIOL: assert property (
        fault_in.instr_viol && !fault_in.data_viol |=> flags[`MF_INSTR] && !mem_addr_wr_out)
        else $error("instruction violation not recorded");

    AST_BUS_STACK: assert property (
        fault_in.bus_stack && !fault_in.precise |=> flags[`BF_STACK] && !bus_addr_wr_out)
        else $error("bus stacking error not recorded");

    AST_BUS_UNSTACK: assert property (
        fault_in.bus_unstack |=> flags[`BF_UNSTACK] && handler_chain_out)
        else $error("bus unstacking error not chained");

    AST_IMPRECISE_PEND: assert property (
        fault_in.imprecise && hc_q[`HC_BUS_ENA]
        |=> flags[`BF_IMPRECISE] && hc_q[`HC_BUS_PEND] && !bus_addr_wr_out)
        else $error("imprecise error not left pending");

    AST_BOTH_FLAGS: assert property (
        flags[`BF_IMPRECISE] && fault_in.precise && !sw_clr[`BF_IMPRECISE]
        |=> flags[`BF_IMPRECISE] && flags[`BF_PRECISE])
        else $error("imprecise and precise flags not seen together");

    AST_MEM_STICKY: assert property (
        flags[`MF_DATA] && !sw_clr[`MF_DATA] |=> flags[`MF_DATA])
        else $error("mem flag dropped without a clear");

    AST_HC_WRITE: assert property (
        hit_ok && req_in.write && hit_hc && lanes[0] && !exc_in.enter && !exc_in.ret
        |=> hc_q[`HC_MEM_ACT] == $past(req_in.wdata[`HC_MEM_ACT]))
        else $error("handler state write did not land");

    AST_BUS_BYTE_READ: assert property (
        req_in.valid && !req_in.write && hit_fault && req_in.size == SZ_BYTE
        && req_in.addr[1:0] == 2'b01 |=> rdata_out == {16'h0, $past(flags[15:8]), 8'h0})
        else $error("bus status byte read wrong");

endmodule

/* verification/tb.sv */
// Self-checking bench for the fault status capture block.
`timescale 1ns/100ps
`include "fault_status_regs.svh"
module tb
    import fault_status_pkg::*;
;
    logic        mclk_in;
    logic        resetn_in;
    reg_req_t    req_in;
    fault_evt_t  fault_in;
    exc_evt_t    exc_in;
    logic        resp_valid_out;
    logic        resp_err_out;
    logic [31:0] rdata_out;
    logic        hard_fault_out;
    logic        handler_chain_out;
    logic        mem_addr_wr_out;
    logic        bus_addr_wr_out;
    logic [31:0] fault_addr_out;
    logic [31:0] handler_state_out;
    int          bad_count;
    int          comparisons;
    logic [31:0] cf;
    logic [31:0] hc;
    logic [31:0] fa;
    logic [10:0] tab_fl [0:5] = '{11'h400, 11'h200, 11'h080, 11'h040, 11'h020, 11'h010};
    int          tab_bit [0:5] = '{4, 3, 0, 12, 11, 10};
    logic [3:0]  tab_pl [0:5] = '{4'h0, 4'h4, 4'h0, 4'h0, 4'h4, 4'h0};
    logic [3:0]  ex_num [0:6] = '{4'h4, 4'h5, 4'h6, 4'hb, 4'hc, 4'he, 4'hf};
    int          ex_act [0:6] = '{0, 1, 3, 7, 8, 10, 11};
    int          ex_pnd [0:6] = '{13, 14, 12, 15, -1, -1, -1};

    fault_status_capture u_fault_status_capture (
        .mclk_in           (mclk_in),
        .resetn_in         (resetn_in),
        .req_in            (req_in),
        .fault_in          (fault_in),
        .exc_in            (exc_in),
        .resp_valid_out    (resp_valid_out),
        .resp_err_out      (resp_err_out),
        .rdata_out         (rdata_out),
        .hard_fault_out    (hard_fault_out),
        .handler_chain_out (handler_chain_out),
        .mem_addr_wr_out   (mem_addr_wr_out),
        .bus_addr_wr_out   (bus_addr_wr_out),
        .fault_addr_out    (fault_addr_out),
        .handler_state_out (handler_state_out)
    );

    always #25 mclk_in = ~mclk_in;

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ************************************************************
    // Stimulus tasks
    // ************************************************************
    // One register access; the answer is waited for under a small bound.
    task automatic acc(input logic wr, input acc_size_t sz, input logic [31:0] a,
                       input logic [31:0] wd, input logic e_err, input logic [31:0] e_rd);
        int n;
        n = 0;
        @(negedge mclk_in);
        req_in <= {1'b1, wr, sz, a, wd};
        @(negedge mclk_in);
        req_in.valid <= 1'b0;
        while (resp_valid_out !== 1'b1 && n < 3) begin
            @(negedge mclk_in);
            n++;
        end
        if (n == 3) begin
            bad_count++;
            $display("unexpected response wait expected %h seen %h", 1'b1, resp_valid_out);
            final_report();
        end
        chk("resp_err", {31'h0, e_err}, {31'h0, resp_err_out});
        chk("rdata", e_rd, rdata_out);
    endtask

    // Pulses are gathered over two samples so a one-cycle answer is never missed.
    task automatic fire(input logic [10:0] fl, input logic [15:0] us, input logic [31:0] a,
                        input logic [3:0] ep);
        logic [3:0] seen;
        @(negedge mclk_in);
        fault_in <= {fl, us, a};
        @(negedge mclk_in);
        fault_in <= '0;
        seen = {hard_fault_out, handler_chain_out, mem_addr_wr_out, bus_addr_wr_out};
        @(negedge mclk_in);
        seen = seen | {hard_fault_out, handler_chain_out, mem_addr_wr_out, bus_addr_wr_out};
        chk("fault pulses", {28'h0, ep}, {28'h0, seen});
        chk("fault addr", fa, fault_addr_out);
    endtask

    task automatic exc(input logic en, input logic rt, input logic [3:0] num, input logic sv);
        @(negedge mclk_in);
        exc_in <= {en, rt, num, sv};
        @(negedge mclk_in);
        exc_in <= '0;
        @(negedge mclk_in);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        mclk_in = 1'b0;
        resetn_in = 1'b0;
        req_in = '0;
        fault_in = '0;
        exc_in = '0;
        bad_count = 0;
        comparisons = 0;
        cf = 32'h0;
        hc = 32'h0;
        fa = 32'h0;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
        resetn_in = 1'b1;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, `FAULT_RESET);
        acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, `HC_RESET);
        acc(1'b0, SZ_WORD, 32'he000ed30, 32'h0, 1'b1, 32'h0);
        acc(1'b0, SZ_HALF, `BUS_FAULT_STAT_ADDR, 32'h0, 1'b1, 32'h0);
        acc(1'b1, SZ_WORD, 32'he000ed2a, 32'hffffffff, 1'b1, 32'h0);
        // Handlers are disabled after reset, so every fault escalates.
        fa = 32'h2000_1234;
        fire(11'h008, 16'h0, fa, 4'h9);
        cf = cf | 32'h0000_8200;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        fa = 32'h2000_5678;
        fire(11'h100, 16'h0, fa, 4'ha);
        cf = (cf | 32'h0000_0082) & ~32'h0000_8000;
        fire(11'h000, 16'h0301, 32'h0, 4'h8);
        cf = cf | 32'h0301_0000;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        acc(1'b0, SZ_BYTE, `MEM_FAULT_STAT_ADDR, 32'h0, 1'b0, {24'h0, cf[7:0]});
        acc(1'b0, SZ_HALF, `COMB_FAULT_ADDR, 32'h0, 1'b0, {16'h0, cf[15:0]});
        acc(1'b0, SZ_BYTE, `BUS_FAULT_STAT_ADDR, 32'h0, 1'b0, {16'h0, cf[15:8], 8'h0});
        acc(1'b0, SZ_HALF, `USG_FAULT_STAT_ADDR, 32'h0, 1'b0, {cf[31:16], 16'h0});
        acc(1'b1, SZ_BYTE, `MEM_FAULT_STAT_ADDR, 32'h0000_0080, 1'b0, 32'h0);
        fa = 32'h2000_9abc;
        fire(11'h008, 16'h0, fa, 4'h9);
        acc(1'b1, SZ_BYTE, `BUS_FAULT_STAT_ADDR, 32'h0000_8000, 1'b0, 32'h0);
        cf = cf & ~32'h0000_0080;
        // Handler control: reserved bits read 0, then only the enables stay set.
        acc(1'b1, SZ_WORD, `HANDLER_CTRL_ADDR, 32'hffffffff, 1'b0, 32'h0);
        acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, `HC_IMPL_MASK);
        hc = 32'h0007_0000;
        acc(1'b1, SZ_WORD, `HANDLER_CTRL_ADDR, hc, 1'b0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            fire(tab_fl[i], 16'h0, 32'hdead_0000, tab_pl[i]);
            cf = cf | (32'h1 << tab_bit[i]);
            hc = hc | (32'h1 << ((i < 3) ? 13 : 14));
        end
        fa = 32'h2000_4321;
        fire(11'h008, 16'h0, fa, 4'h1);
        cf = cf | 32'h0000_8200;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, hc);
        // A flushed prefetch must never surface as an instruction bus error.
        fire(11'h004, 16'h0, 32'h0, 4'h0);
        fire(11'h001, 16'h0, 32'h0, 4'h0);
        fire(11'h002, 16'h0, 32'h0, 4'h0);
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        fire(11'h004, 16'h0, 32'h0, 4'h0);
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        fire(11'h002, 16'h0, 32'h0, 4'h0);
        cf = cf | 32'h0000_0100;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        // Write-one-to-clear through each access width.
        acc(1'b1, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, 32'h0);
        acc(1'b1, SZ_WORD, `COMB_FAULT_ADDR, 32'h0001_0018, 1'b0, 32'h0);
        cf = cf & ~32'h0001_0018;
        acc(1'b1, SZ_BYTE, `BUS_FAULT_STAT_ADDR, 32'h0000_0100, 1'b0, 32'h0);
        cf = cf & ~32'h0000_0100;
        acc(1'b1, SZ_HALF, `USG_FAULT_STAT_ADDR, 32'h0200_0000, 1'b0, 32'h0);
        cf = cf & ~32'h0200_0000;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, cf);
        // Exception entry sets the active bit and drops the pending bit.
        exc(1'b0, 1'b0, 4'h0, 1'b1);
        hc = hc | 32'h0000_8000;
        for (int i = 0; i < 7; i++) begin
            exc(1'b1, 1'b0, ex_num[i], 1'b0);
            hc = hc | (32'h1 << ex_act[i]);
            if (ex_pnd[i] >= 0) begin
                hc = hc & ~(32'h1 << ex_pnd[i]);
            end
            acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, hc);
            chk("handler state", hc, handler_state_out);
        end
        for (int i = 0; i < 7; i++) begin
            exc(1'b0, 1'b1, ex_num[i], 1'b0);
            hc = hc & ~(32'h1 << ex_act[i]);
        end
        acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, hc);
        @(negedge mclk_in);
        resetn_in = 1'b0;
        @(negedge mclk_in);
        resetn_in = 1'b1;
        acc(1'b0, SZ_WORD, `COMB_FAULT_ADDR, 32'h0, 1'b0, `FAULT_RESET);
        acc(1'b0, SZ_WORD, `HANDLER_CTRL_ADDR, 32'h0, 1'b0, `HC_RESET);
        final_report();
    end
endmodule
